/* common/bct_pkg.sv */
// Purpose: shared constants and types of the calendar timekeeper
// Assumes: 4-bit register window, 40 MHz system clock
// Notes: all time counters are BCD nibbles; the leap counter is two binary bits
`default_nettype none
package bct_pkg;
    // register offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_TENTHS = 4'h1;
    localparam logic [3:0] OFS_SEC_U = 4'h2;
    localparam logic [3:0] OFS_SEC_T = 4'h3;
    localparam logic [3:0] OFS_MIN_U = 4'h4;
    localparam logic [3:0] OFS_MIN_T = 4'h5;
    localparam logic [3:0] OFS_HR_U = 4'h6;
    localparam logic [3:0] OFS_HR_T = 4'h7;
    localparam logic [3:0] OFS_DAY_U = 4'h8;
    localparam logic [3:0] OFS_DAY_T = 4'h9;
    localparam logic [3:0] OFS_MON_U = 4'hA;
    localparam logic [3:0] OFS_MON_T = 4'hB;
    localparam logic [3:0] OFS_YR_U = 4'hC;
    localparam logic [3:0] OFS_YR_T = 4'hD;
    localparam logic [3:0] OFS_WDAY = 4'hE;
    localparam logic [3:0] OFS_WINDOW = 4'hF;
    // control register fields
    localparam int CTL_TEST_BIT = 3;
    localparam int CTL_STOP_BIT = 2;
    localparam int CTL_ISEL_BIT = 1;
    localparam int CTL_ISTOP_BIT = 0;
    localparam int STS_DCHG_BIT = 3;
    localparam int STS_IFLAG_BIT = 0;
    // clock setting register fields
    localparam int SET_FMT_BIT = 0;
    localparam int SET_PM_BIT = 1;
    localparam int SET_LEAP_LSB = 2;
    // interrupt register fields
    localparam int IRQ_REP_BIT = 3;
    localparam logic [2:0] IRQ_CODE_NONE = 3'h0;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SET_PULSE_NS = 100_000_000;
    localparam int SET_PULSE_CYCLES = SET_PULSE_NS / CLK_PERIOD_NS;
    // reset values
    localparam logic [3:0] RST_ZERO = 4'h0;
    localparam logic [3:0] RST_ONE = 4'h1;
    localparam logic [3:0] RST_HR_U = 4'h2;
    localparam logic [3:0] RST_HR_T = 4'h1;
    localparam logic [1:0] RST_LEAP = 2'h0;

    typedef struct packed {
        logic [3:0] tenths;
        logic [3:0] sec_u;
        logic [3:0] sec_t;
        logic [3:0] min_u;
        logic [3:0] min_t;
        logic [3:0] hr_u;
        logic [3:0] hr_t;
        logic [3:0] day_u;
        logic [3:0] day_t;
        logic [3:0] mon_u;
        logic [3:0] mon_t;
        logic [3:0] yr_u;
        logic [3:0] yr_t;
        logic [3:0] wday;
    } bct_time_t;

    typedef struct packed {
        bct_time_t tm;
        logic fmt24;
        logic pm;
        logic [1:0] leap;
        logic [2:0] irq_code;
        logic irq_rep;
        logic ctl_test;
        logic ctl_stop;
        logic ctl_isel;
        logic ctl_istop;
        logic dchg;
        logic ws_d;
        logic rs_d;
        logic [3:0] wr_addr;
        logic [3:0] wr_data;
        logic [3:0] rd_addr;
        logic [3:0] dout;
        logic [21:0] presc;
    } bct_state_t;
endpackage : bct_pkg
`default_nettype wire

/* rtl/bct_timekeeper.sv */
// Purpose: BCD calendar timekeeper with 4-bit parallel register port
// Assumes: bus pins synchronous to CLK; 10 Hz setting pulse made from CLK
// Notes: writes commit at the trailing edge of the write strobe
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - clock stop bit clears tenths counter
// - seconds writable, all three readable
// - 12-hour: one tens-of-hours bit active
// - 24-hour: two tens bits, meridiem reads zero
// - units of hours uses four bits
// - meridiem toggles at 11:59 to 12:00
// - setting bit 0 selects hour format
// - day limit follows month and leap
// - years count to 99, wrap 00
// - weekday advances at midnight rollover
// - weekday cycles 1 to 7
// - 4-bit register address decode
// - select bit picks address 15 register
// - leap counter steps at new year
// - leap counter zero allows February 29
// - all setting bits read back
// - interrupt register low bits hold delay
// - interrupt bit 3 selects repeat mode
// - code zero sets interrupt stop bit
// - select 0 setting, 1 interrupt register
// - unused counter bits read zero
// - counters advance together every 100 ms
module bct_timekeeper #(
    parameter int TICK_CYCLES = bct_pkg::SET_PULSE_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // processor strobes
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [3:0] REGISTER_SELECT_LINES,
    // data lines, split
    input wire logic [3:0] BUS_BIT_LINES_I,
    output logic [3:0] BUS_BIT_LINES_O,
    output logic BUS_BIT_LINES_OE_N
);

    bct_pkg::bct_state_t s_reg;
    bct_pkg::bct_state_t s_next;
    logic ws;
    logic rs;
    logic tick;
    logic ws_end;
    logic rs_start;
    logic rs_end;

    // next value of a BCD pair, wrapping to lo after hi
    function automatic logic [7:0] pair_inc(input logic [3:0] t, input logic [3:0] u,
                                            input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] r;
        r = {t, u};
        if (r == hi) begin
            r = lo;
        end else if (u == 4'h9) begin
            r = {t + 4'h1, 4'h0};
        end else begin
            r = {t, u + 4'h1};
        end
        return r;
    endfunction : pair_inc

    // last day of month as BCD pair
    function automatic logic [7:0] month_end(input logic [3:0] mt, input logic [3:0] mu,
                                             input logic [1:0] leap);
        logic [7:0] r;
        r = 8'h31;
        if (mt == 4'h0 && mu == 4'h2) begin
            r = (leap == 2'h0) ? 8'h29 : 8'h28;
        end else if ((mt == 4'h0 && (mu == 4'h4 || mu == 4'h6 || mu == 4'h9)) ||
                     (mt == 4'h1 && mu == 4'h1)) begin
            r = 8'h30;
        end
        return r;
    endfunction : month_end

    // read data for an address
    function automatic logic [3:0] read_mux(input bct_pkg::bct_state_t st, input logic [3:0] a);
        logic [3:0] r;
        r = 4'h0;
        unique case (a)
            bct_pkg::OFS_CTRL: begin
                r[bct_pkg::STS_DCHG_BIT] = st.dchg;
                r[bct_pkg::STS_IFLAG_BIT] = 1'b0;
            end
            bct_pkg::OFS_TENTHS: r = st.tm.tenths;
            bct_pkg::OFS_SEC_U: r = st.tm.sec_u;
            bct_pkg::OFS_SEC_T: r = {1'b0, st.tm.sec_t[2:0]};
            bct_pkg::OFS_MIN_U: r = st.tm.min_u;
            bct_pkg::OFS_MIN_T: r = {1'b0, st.tm.min_t[2:0]};
            bct_pkg::OFS_HR_U: r = st.tm.hr_u;
            bct_pkg::OFS_HR_T: begin
                if (st.fmt24) begin
                    r = {2'b00, st.tm.hr_t[1:0]};
                end else begin
                    r = {3'b000, st.tm.hr_t[0]};
                end
            end
            bct_pkg::OFS_DAY_U: r = st.tm.day_u;
            bct_pkg::OFS_DAY_T: r = {2'b00, st.tm.day_t[1:0]};
            bct_pkg::OFS_MON_U: r = st.tm.mon_u;
            bct_pkg::OFS_MON_T: r = {3'b000, st.tm.mon_t[0]};
            bct_pkg::OFS_YR_U: r = st.tm.yr_u;
            bct_pkg::OFS_YR_T: r = st.tm.yr_t;
            bct_pkg::OFS_WDAY: r = {1'b0, st.tm.wday[2:0]};
            bct_pkg::OFS_WINDOW: begin
                if (st.ctl_isel) begin
                    r = {st.irq_rep, st.irq_code};
                end else begin
                    r = {st.leap, st.pm & ~st.fmt24, st.fmt24};
                end
            end
        endcase
        return r;
    endfunction : read_mux

    assign ws = ~CS_N & ~WR_N;
    assign rs = ~CS_N & ~RD_N;
    assign ws_end = s_reg.ws_d & ~ws;
    assign rs_start = rs & ~s_reg.rs_d;
    assign rs_end = s_reg.rs_d & ~rs;
    assign tick = ~s_reg.ctl_stop && (s_reg.presc == 22'(TICK_CYCLES - 1));

    always_comb begin
        logic [7:0] p;
        logic c_sec;
        logic c_min;
        logic c_hr;
        logic c_day;
        logic c_mon;
        logic c_yr;
        logic [3:0] d;
        p = 8'h00;
        c_sec = 1'b0;
        c_min = 1'b0;
        c_hr = 1'b0;
        c_day = 1'b0;
        c_mon = 1'b0;
        c_yr = 1'b0;
        d = s_reg.wr_data;
        s_next = s_reg;
        s_next.ws_d = ws;
        s_next.rs_d = rs;

        // prescaler making the setting pulse
        if (s_reg.ctl_stop || tick) begin
            s_next.presc = 22'h00_0000;
        end else begin
            s_next.presc = s_reg.presc + 22'h00_0001;
        end

        // synchronous cascade on the setting pulse
        if (tick) begin
            s_next.dchg = 1'b1;
            if (s_reg.tm.tenths == 4'h9) begin
                s_next.tm.tenths = 4'h0;
                c_sec = 1'b1;
            end else begin
                s_next.tm.tenths = s_reg.tm.tenths + 4'h1;
            end
            if (c_sec) begin
                p = pair_inc(s_reg.tm.sec_t, s_reg.tm.sec_u, 8'h59, 8'h00);
                {s_next.tm.sec_t, s_next.tm.sec_u} = p;
                c_min = ({s_reg.tm.sec_t, s_reg.tm.sec_u} == 8'h59);
            end
            if (c_min) begin
                p = pair_inc(s_reg.tm.min_t, s_reg.tm.min_u, 8'h59, 8'h00);
                {s_next.tm.min_t, s_next.tm.min_u} = p;
                c_hr = ({s_reg.tm.min_t, s_reg.tm.min_u} == 8'h59);
            end
            if (c_hr) begin
                if (s_reg.fmt24) begin
                    p = pair_inc(s_reg.tm.hr_t, s_reg.tm.hr_u, 8'h23, 8'h00);
                    c_day = ({s_reg.tm.hr_t, s_reg.tm.hr_u} == 8'h23);
                    s_next.pm = 1'b0;
                end else begin
                    p = pair_inc(s_reg.tm.hr_t, s_reg.tm.hr_u, 8'h12, 8'h01);
                    if ({s_reg.tm.hr_t, s_reg.tm.hr_u} == 8'h11) begin
                        s_next.pm = ~s_reg.pm;
                        c_day = s_reg.pm;
                    end
                end
                {s_next.tm.hr_t, s_next.tm.hr_u} = p;
            end
            if (c_day) begin
                if (s_reg.tm.wday[2:0] == 3'h7) begin
                    s_next.tm.wday = 4'h1;
                end else begin
                    s_next.tm.wday = {1'b0, s_reg.tm.wday[2:0] + 3'h1};
                end
                p = month_end(s_reg.tm.mon_t, s_reg.tm.mon_u, s_reg.leap);
                c_mon = ({s_reg.tm.day_t, s_reg.tm.day_u} >= p);
                if (c_mon) begin
                    {s_next.tm.day_t, s_next.tm.day_u} = 8'h01;
                end else begin
                    {s_next.tm.day_t, s_next.tm.day_u} =
                        pair_inc(s_reg.tm.day_t, s_reg.tm.day_u, 8'h31, 8'h01);
                end
            end
            if (c_mon) begin
                p = pair_inc(s_reg.tm.mon_t, s_reg.tm.mon_u, 8'h12, 8'h01);
                {s_next.tm.mon_t, s_next.tm.mon_u} = p;
                c_yr = ({s_reg.tm.mon_t, s_reg.tm.mon_u} == 8'h12);
            end
            if (c_yr) begin
                p = pair_inc(s_reg.tm.yr_t, s_reg.tm.yr_u, 8'h99, 8'h00);
                {s_next.tm.yr_t, s_next.tm.yr_u} = p;
                s_next.leap = s_reg.leap + 2'h1;
            end
        end

        // sample address and data while write strobe is active
        if (ws) begin
            s_next.wr_addr = REGISTER_SELECT_LINES;
            s_next.wr_data = BUS_BIT_LINES_I;
        end

        // commit at trailing edge of write strobe; write beats the tick
        if (ws_end) begin
            unique case (s_reg.wr_addr)
                bct_pkg::OFS_CTRL: begin
                    s_next.ctl_test = d[bct_pkg::CTL_TEST_BIT];
                    s_next.ctl_stop = d[bct_pkg::CTL_STOP_BIT];
                    s_next.ctl_isel = d[bct_pkg::CTL_ISEL_BIT];
                    s_next.ctl_istop = d[bct_pkg::CTL_ISTOP_BIT] |
                                       (s_reg.irq_code == bct_pkg::IRQ_CODE_NONE);
                end
                bct_pkg::OFS_TENTHS: s_next.tm.tenths = s_next.tm.tenths;
                bct_pkg::OFS_SEC_U: s_next.tm.sec_u = d;
                bct_pkg::OFS_SEC_T: s_next.tm.sec_t = {1'b0, d[2:0]};
                bct_pkg::OFS_MIN_U: s_next.tm.min_u = d;
                bct_pkg::OFS_MIN_T: s_next.tm.min_t = {1'b0, d[2:0]};
                bct_pkg::OFS_HR_U: s_next.tm.hr_u = d;
                bct_pkg::OFS_HR_T: begin
                    s_next.tm.hr_t = s_reg.fmt24 ? {2'b00, d[1:0]} : {3'b000, d[0]};
                end
                bct_pkg::OFS_DAY_U: s_next.tm.day_u = d;
                bct_pkg::OFS_DAY_T: s_next.tm.day_t = {2'b00, d[1:0]};
                bct_pkg::OFS_MON_U: s_next.tm.mon_u = d;
                bct_pkg::OFS_MON_T: s_next.tm.mon_t = {3'b000, d[0]};
                bct_pkg::OFS_YR_U: s_next.tm.yr_u = d;
                bct_pkg::OFS_YR_T: s_next.tm.yr_t = d;
                bct_pkg::OFS_WDAY: s_next.tm.wday = {1'b0, d[2:0]};
                bct_pkg::OFS_WINDOW: begin
                    if (s_reg.ctl_isel) begin
                        s_next.irq_code = d[2:0];
                        s_next.irq_rep = d[bct_pkg::IRQ_REP_BIT];
                        if (d[2:0] == bct_pkg::IRQ_CODE_NONE) begin
                            s_next.ctl_istop = 1'b1;
                        end
                    end else begin
                        s_next.fmt24 = d[bct_pkg::SET_FMT_BIT];
                        s_next.pm = d[bct_pkg::SET_PM_BIT] & ~d[bct_pkg::SET_FMT_BIT];
                        s_next.leap = d[bct_pkg::SET_LEAP_LSB +: 2];
                    end
                end
            endcase
        end

        // clock stop holds tenths at zero
        if (s_next.ctl_stop) begin
            s_next.tm.tenths = 4'h0;
        end

        // read data latched at start of read strobe
        if (rs_start) begin
            s_next.rd_addr = REGISTER_SELECT_LINES;
            s_next.dout = read_mux(s_reg, REGISTER_SELECT_LINES);
        end

        // control read clears data-changed unless a tick lands now
        if (rs_end && s_reg.rd_addr == bct_pkg::OFS_CTRL && !tick) begin
            s_next.dchg = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_reg.tm.tenths <= bct_pkg::RST_ZERO;
            s_reg.tm.sec_u <= bct_pkg::RST_ZERO;
            s_reg.tm.sec_t <= bct_pkg::RST_ZERO;
            s_reg.tm.min_u <= bct_pkg::RST_ZERO;
            s_reg.tm.min_t <= bct_pkg::RST_ZERO;
            s_reg.tm.hr_u <= bct_pkg::RST_HR_U;
            s_reg.tm.hr_t <= bct_pkg::RST_HR_T;
            s_reg.tm.day_u <= bct_pkg::RST_ONE;
            s_reg.tm.day_t <= bct_pkg::RST_ZERO;
            s_reg.tm.mon_u <= bct_pkg::RST_ONE;
            s_reg.tm.mon_t <= bct_pkg::RST_ZERO;
            s_reg.tm.yr_u <= bct_pkg::RST_ZERO;
            s_reg.tm.yr_t <= bct_pkg::RST_ZERO;
            s_reg.tm.wday <= bct_pkg::RST_ONE;
            s_reg.fmt24 <= 1'b0;
            s_reg.pm <= 1'b0;
            s_reg.leap <= bct_pkg::RST_LEAP;
            s_reg.irq_code <= bct_pkg::IRQ_CODE_NONE;
            s_reg.irq_rep <= 1'b0;
            s_reg.ctl_test <= 1'b0;
            s_reg.ctl_stop <= 1'b0;
            s_reg.ctl_isel <= 1'b0;
            s_reg.ctl_istop <= 1'b1;
            s_reg.dchg <= 1'b0;
            s_reg.ws_d <= 1'b0;
            s_reg.rs_d <= 1'b0;
            s_reg.wr_addr <= bct_pkg::RST_ZERO;
            s_reg.wr_data <= bct_pkg::RST_ZERO;
            s_reg.rd_addr <= bct_pkg::RST_ZERO;
            s_reg.dout <= bct_pkg::RST_ZERO;
            s_reg.presc <= 22'h00_0000;
        end else begin
            s_reg <= s_next;
        end
    end

    assign BUS_BIT_LINES_O = s_reg.dout;
    assign BUS_BIT_LINES_OE_N = ~(rs & s_reg.rs_d);

endmodule : bct_timekeeper
`default_nettype wire

/* dv/bct_host_model.sv */
// Purpose: processor model on the 4-bit register port
// Assumes: strobes change just after a rising edge
// Notes: a released data line shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module bct_host_model (
    // clock
    input wire logic clk,
    // strobes and address
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] addr,
    // data lines
    output logic [3:0] d_drv,
    input wire logic [3:0] bus_in
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 4'h0;
        d_drv = 4'h0;
    end

    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        d_drv <= d;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge clk);
        d_drv <= ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [3:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        repeat (2) @(posedge clk);
        d = bus_in;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask : rd

    // format first, meridiem in a second write for 12-hour format only
    task automatic set_mode(input logic fmt, input logic pm, input logic [1:0] leap);
        wr(4'hF, {leap, 1'b0, fmt});
        if (!fmt) begin
            wr(4'hF, {leap, pm, fmt});
        end
    endtask : set_mode
endmodule : bct_host_model
`default_nettype wire

/* dv/bct_timekeeper_checker.sv */
// Purpose: port checks of the calendar timekeeper
// Assumes: address held for the whole read strobe
// Notes: attached by bind
`timescale 1ns/1ps
`default_nettype none
module bct_timekeeper_checker #(
    parameter int TICK_CYCLES = 10
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // strobes and address
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [3:0] REGISTER_SELECT_LINES,
    // data lines
    input wire logic [3:0] BUS_BIT_LINES_I,
    input wire logic [3:0] BUS_BIT_LINES_O,
    input wire logic BUS_BIT_LINES_OE_N
);
    logic rs;
    logic rd_ok;
    assign rs = !CS_N && !RD_N;
    assign rd_ok = !BUS_BIT_LINES_OE_N;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    oe_drive_a: assert property ($rose(rs) ##1 rs |-> rd_ok)
        else $error("drive enable late");
    oe_release_a: assert property (!rs |-> !rd_ok)
        else $error("drive enable without read");
    read_hold_a: assert property (rd_ok && $past(rd_ok) |-> $stable(BUS_BIT_LINES_O))
        else $error("read data moved");
    tenths_bcd_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'h1 |-> BUS_BIT_LINES_O <= 4'h9)
        else $error("tenths not bcd");
    sec_tens_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'h3 |-> BUS_BIT_LINES_O <= 4'h5)
        else $error("tens of seconds range");
    hr_tens_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'h7 |-> BUS_BIT_LINES_O[3:2] == 2'b00)
        else $error("tens of hours high bits");
    day_tens_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'h9 |-> BUS_BIT_LINES_O[3:2] == 2'b00)
        else $error("tens of days high bits");
    mon_tens_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'hB |-> BUS_BIT_LINES_O[3:1] == 3'b000)
        else $error("tens of months high bits");
    wday_range_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'hE |-> BUS_BIT_LINES_O inside {[1:7]})
        else $error("weekday out of range");
    ctrl_read_a: assert property (rd_ok && REGISTER_SELECT_LINES == 4'h0 |-> BUS_BIT_LINES_O[2:0] == 3'b000)
        else $error("control read low bits");
endmodule : bct_timekeeper_checker
bind bct_timekeeper bct_timekeeper_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N),
    .REGISTER_SELECT_LINES(REGISTER_SELECT_LINES), .BUS_BIT_LINES_I(BUS_BIT_LINES_I),
    .BUS_BIT_LINES_O(BUS_BIT_LINES_O), .BUS_BIT_LINES_OE_N(BUS_BIT_LINES_OE_N));
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench of the calendar timekeeper
// Assumes: 10 clocks per setting pulse
// Notes: table entries are {address, data}
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk;
    logic resetn;
    logic cs_n, rd_n, wr_n, oe_n;
    logic [3:0] addr, d_drv, dout;
    wire [3:0] bus;
    int fails = 0;
    int n_tests = 0;

    bct_timekeeper #(.TICK_CYCLES(10)) uut (.CLK(clk), .RESETN(resetn), .CS_N(cs_n), .RD_N(rd_n),
        .WR_N(wr_n), .REGISTER_SELECT_LINES(addr), .BUS_BIT_LINES_I(bus), .BUS_BIT_LINES_O(dout),
        .BUS_BIT_LINES_OE_N(oe_n));
    bct_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .d_drv(d_drv), .bus_in(bus));
    assign bus = !oe_n ? dout : d_drv;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic wrap_up();
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rchk(input logic [3:0] a, input logic [3:0] exp);
        logic [3:0] v;
        host.rd(a, v);
        check(v, exp);
    endtask : rchk

    task automatic run_tbl(input logic [7:0] t[$], input bit wr);
        foreach (t[i]) begin
            if (wr) host.wr(t[i][7:4], t[i][3:0]);
            else rchk(t[i][7:4], t[i][3:0]);
        end
    endtask : run_tbl

    // run the clock about fifteen setting pulses, then stop it
    task automatic run_clock();
        host.wr(bct_pkg::OFS_CTRL, 4'h0);
        repeat (150) @(posedge clk);
        host.wr(bct_pkg::OFS_CTRL, 4'h4);
    endtask : run_clock

    task automatic t_stop();
        logic [3:0] v;
        host.wr(bct_pkg::OFS_CTRL, 4'h4);
        repeat (30) @(posedge clk);
        rchk(bct_pkg::OFS_TENTHS, 4'h0);
        host.rd(bct_pkg::OFS_CTRL, v);
        rchk(bct_pkg::OFS_CTRL, 4'h0);
        host.wr(bct_pkg::OFS_TENTHS, 4'h5);
        rchk(bct_pkg::OFS_TENTHS, 4'h0);
    endtask : t_stop

    task automatic t_masks();
        logic [7:0] q[$];
        q = '{8'h29, 8'h3D, 8'h48, 8'h5C, 8'h61, 8'h7F, 8'h87, 8'h9E, 8'hA2, 8'hBF, 8'hC9, 8'hD9, 8'hEB};
        run_tbl(q, 1'b1);
        q = '{8'h29, 8'h35, 8'h48, 8'h54, 8'h61, 8'h71, 8'h87, 8'h92, 8'hA2, 8'hB1, 8'hC9, 8'hD9, 8'hE3};
        run_tbl(q, 1'b0);
    endtask : t_masks

    task automatic t_hour24();
        logic [7:0] q[$];
        host.set_mode(1'b1, 1'b0, 2'd2);
        q = '{8'h63, 8'h7E};
        run_tbl(q, 1'b1);
        q = '{8'h63, 8'h72};
        run_tbl(q, 1'b0);
        q = '{8'h7D, 8'h68};
        run_tbl(q, 1'b1);
        q = '{8'h71, 8'h68, 8'hF9};
        run_tbl(q, 1'b0);
    endtask : t_hour24

    // 11:59:59 PM Dec 31 of year 99 rolls into the next year
    task automatic t_roll();
        logic [7:0] q[$];
        host.set_mode(1'b0, 1'b1, 2'd3);
        q = '{8'h29, 8'h35, 8'h49, 8'h55, 8'h61, 8'h71, 8'h81, 8'h93, 8'hA2, 8'hB1, 8'hC9, 8'hD9, 8'hE7};
        run_tbl(q, 1'b1);
        run_clock();
        q = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h62, 8'h71, 8'h81, 8'h90, 8'hA1, 8'hB0, 8'hC0, 8'hD0, 8'hE1, 8'hF0};
        run_tbl(q, 1'b0);
        // fifteen pulses ran, so only the stop write can have zeroed tenths
        rchk(bct_pkg::OFS_TENTHS, 4'h0);
        rchk(bct_pkg::OFS_CTRL, 4'h8);
        rchk(bct_pkg::OFS_CTRL, 4'h0);
    endtask : t_roll

    // 23:59:59 on February 28
    task automatic t_leap(input logic [1:0] lp);
        logic [7:0] q[$];
        host.set_mode(1'b1, 1'b0, lp);
        q = '{8'h29, 8'h35, 8'h49, 8'h55, 8'h63, 8'h72, 8'h88, 8'h92, 8'hA2, 8'hB0};
        run_tbl(q, 1'b1);
        run_clock();
        rchk(bct_pkg::OFS_DAY_U, (lp == 2'd0) ? 4'h9 : 4'h1);
        rchk(bct_pkg::OFS_DAY_T, (lp == 2'd0) ? 4'h2 : 4'h0);
        rchk(bct_pkg::OFS_MON_U, (lp == 2'd0) ? 4'h2 : 4'h3);
        rchk(bct_pkg::OFS_HR_T, 4'h0);
        rchk(bct_pkg::OFS_WINDOW, {lp, 2'b01});
    endtask : t_leap

    task automatic t_irq();
        host.wr(bct_pkg::OFS_CTRL, 4'h6);
        host.wr(bct_pkg::OFS_WINDOW, 4'hB);
        rchk(bct_pkg::OFS_WINDOW, 4'hB);
        host.wr(bct_pkg::OFS_CTRL, 4'h4);
        rchk(bct_pkg::OFS_WINDOW, 4'h5);
    endtask : t_irq

    initial begin
        resetn = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_stop();
        t_masks();
        t_hour24();
        t_roll();
        t_leap(2'd0);
        t_leap(2'd1);
        t_irq();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
